//--- dps_pin_mux.sv
// Summary of operation
// (RULE1) Select high, route 10: data clock on SDO.
// (RULE2) Select low: SDO carries SPI output data.
// (RULE3) Route 11, no enables: data clock on IRQ.
// (RULE4) Source 01: SDI is direct data pin.
// (RULE5) TX samples host SDI; RX drives demodulated SDI.
// (RULE6) SDO carries interrupt when routing bit set.
// (RULE7) Test mode takes TX data from PN9.
// (RULE8) Sync detector enabled only after preamble.
// (RULE9) Square data clock; one bit per cycle. In TX a full buffer stretches the low half.
// (RULE10) Route 00 none, 01 GPIO, 10 SDO, 11 IRQ.
// (RULE11) PN9 x^9+x^5+1, nonzero seed, per bit.
`timescale 1ns/100ps
`default_nettype none
`include "dps_defs.svh"
module dps_pin_mux (
  input  wire logic                     mclk,
  input  wire logic                     nrst,
  input  wire logic                     serial_select_n,
  input  wire logic                     sdi_i,
  output logic                          sdi_o,
  output logic                          sdi_oe_n,
  output logic                          sdo_o,
  output logic                          sdo_oe_n,
  output logic                          interrupt_out_n,
  input  wire logic                     gpio_data_i,
  output logic                          gpio_clk_o,
  input  wire logic                     spi_sdo,
  input  wire logic                     spi_sdo_oe_n,
  input  wire logic                     irq_int_n,
  input  wire logic [`DPS_INT_EN_W-1:0] int_en1,
  input  wire logic [`DPS_INT_EN_W-1:0] int_en2,
  input  wire logic                     irq_on_sdo,
  input  wire logic [1:0]               clk_route,
  input  wire logic [1:0]               src_sel,
  input  wire logic                     pn9_mode,
  input  wire logic                     tx_mode,
  input  wire logic                     rx_mode,
  input  wire logic [`DPS_DIV_W-1:0]    half_period,
  input  wire logic                     rx_bit,
  input  wire logic                     preamble_det,
  output logic                          sync_det_en,
  output logic                          tx_valid,
  input  wire logic                     tx_ready,
  output logic                          tx_data
);
  function automatic logic link_on(input logic tx, input logic rx);
    link_on = tx || rx;
  endfunction

  logic                  sel_meta_reg;
  logic                  sel_sync_reg;
  logic                  sdi_meta_reg;
  logic                  sdi_sync_reg;
  logic                  gpio_meta_reg;
  logic                  gpio_sync_reg;
  dps_pkg::dps_clk_st_t  st_reg;
  dps_pkg::dps_clk_st_t  st_next;
  logic [`DPS_DIV_W-1:0] cnt_reg;
  logic [`DPS_DIV_W-1:0] cnt_next;
  logic [`DPS_PN9_MSB:0] pn9_reg;
  logic                  rx_hold_reg;
  logic                  sdo_reg;
  logic                  sdo_oe_n_reg;
  logic                  sdi_o_reg;
  logic                  sdi_oe_n_reg;
  logic                  irq_reg;
  logic                  gpio_clk_reg;
  logic                  sync_en_reg;
  logic                  txv_reg;
  logic                  txd_reg;
  logic                  fifo_in_ready;
  logic                  fifo_out_valid;
  logic                  fifo_out_data;

  wire                   active    = link_on(tx_mode, rx_mode);
  wire [`DPS_DIV_W-1:0]  half_eff  = (half_period == `DPS_DIV_ZERO) ? `DPS_DIV_ONE : half_period;
  wire                   terminal  = (cnt_reg == half_eff - `DPS_DIV_ONE);
  wire                   may_rise  = !tx_mode || fifo_in_ready;
  wire                   rise      = (st_reg == dps_pkg::DPS_CK_LOW) && terminal && may_rise;
  wire                   fall      = (st_reg == dps_pkg::DPS_CK_HIGH) && terminal;
  wire                   dclk      = (st_reg == dps_pkg::DPS_CK_HIGH);
  wire                   sel_high  = sel_sync_reg;
  wire                   src_sdi   = (src_sel == `DPS_SRC_SDI);
  wire                   ints_off  = !(|int_en1) && !(|int_en2);
  wire                   clk_sdo   = sel_high && (clk_route == `DPS_ROUTE_SDO) && active;
  wire                   clk_irq   = (clk_route == `DPS_ROUTE_IRQ) && ints_off;
  wire                   clk_gpio  = (clk_route == `DPS_ROUTE_GPIO);
  wire                   pn9_fb    = pn9_reg[`DPS_PN9_MSB] ^ pn9_reg[`DPS_PN9_TAP];
  wire                   ext_bit   = src_sdi ? sdi_sync_reg : gpio_sync_reg;
  wire                   tx_bit    = pn9_mode ? pn9_reg[`DPS_PN9_MSB] : ext_bit;
  wire                   push      = rise && tx_mode;
  wire                   load_out  = !txv_reg || tx_ready;
  wire                   sdo_next  = !sel_high ? spi_sdo :
                                     clk_sdo ? dclk : irq_int_n;
  wire                   sdo_oe_n_next = !sel_high ? spi_sdo_oe_n :
                                         (clk_sdo || irq_on_sdo) ? 1'b0 : 1'b1;
  wire                   sdi_oe_n_next = !(sel_high && rx_mode && src_sdi);
  wire                   irq_next  = clk_irq ? (!active || dclk) : irq_int_n;
  wire                   sync_next = rx_mode && (sync_en_reg || preamble_det);

  always_comb begin
    st_next  = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      dps_pkg::DPS_CK_IDLE: begin
        cnt_next = `DPS_DIV_ZERO;
        if (active) begin
          st_next = dps_pkg::DPS_CK_LOW;
        end
      end
      dps_pkg::DPS_CK_LOW: begin
        if (!active) begin
          st_next = dps_pkg::DPS_CK_IDLE;
        end else if (rise) begin
          st_next  = dps_pkg::DPS_CK_HIGH;
          cnt_next = `DPS_DIV_ZERO;
        end else if (!terminal) begin
          cnt_next = cnt_reg + `DPS_DIV_ONE;
        end
      end
      dps_pkg::DPS_CK_HIGH: begin
        if (!active) begin
          st_next = dps_pkg::DPS_CK_IDLE;
        end else if (fall) begin
          st_next  = dps_pkg::DPS_CK_LOW;
          cnt_next = `DPS_DIV_ZERO;
        end else begin
          cnt_next = cnt_reg + `DPS_DIV_ONE;
        end
      end
      default: begin
        st_next  = dps_pkg::DPS_CK_IDLE;
        cnt_next = `DPS_DIV_ZERO;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sel_meta_reg  <= 1'b0;
      sel_sync_reg  <= 1'b0;
      sdi_meta_reg  <= 1'b0;
      sdi_sync_reg  <= 1'b0;
      gpio_meta_reg <= 1'b0;
      gpio_sync_reg <= 1'b0;
    end else begin
      sel_meta_reg  <= serial_select_n;
      sel_sync_reg  <= sel_meta_reg;
      sdi_meta_reg  <= sdi_i;
      sdi_sync_reg  <= sdi_meta_reg;
      gpio_meta_reg <= gpio_data_i;
      gpio_sync_reg <= gpio_meta_reg;
    end
  end

  // The data clock has two equal half periods while the TX buffer has room; a full buffer stretches the low half.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_reg  <= dps_pkg::DPS_CK_IDLE;
      cnt_reg <= `DPS_DIV_ZERO;
    end else begin
      st_reg  <= st_next; // RULE9
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pn9_reg <= `DPS_PN9_SEED;
    end else if (push && pn9_mode) begin
      pn9_reg <= {pn9_reg[`DPS_PN9_MSB-1:0], pn9_fb}; // RULE7 RULE11
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_hold_reg <= 1'b0;
    end else if (fall && rx_mode) begin
      rx_hold_reg <= rx_bit; // RULE5
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sdo_reg      <= 1'b0;
      sdo_oe_n_reg <= 1'b1;
      sdi_o_reg    <= 1'b0;
      sdi_oe_n_reg <= 1'b1;
      irq_reg      <= 1'b1;
      gpio_clk_reg <= 1'b0;
      sync_en_reg  <= 1'b0;
    end else begin
      sdo_reg      <= sdo_next; // RULE1 RULE2 RULE6
      sdo_oe_n_reg <= sdo_oe_n_next; // RULE2 RULE6
      sdi_o_reg    <= rx_hold_reg; // RULE5
      sdi_oe_n_reg <= sdi_oe_n_next; // RULE4
      irq_reg      <= irq_next; // RULE3
      gpio_clk_reg <= clk_gpio && dclk; // RULE10
      sync_en_reg  <= sync_next; // RULE8
    end
  end

  // Host data is sampled on the rising clock edge; a full buffer holds the clock low.
  dps_fifo #(
    .WIDTH (`DPS_FIFO_WIDTH),
    .DEPTH (`DPS_FIFO_DEPTH),
    .AW    (`DPS_FIFO_AW)
  ) u_fifo (
    .mclk      (mclk),
    .nrst      (nrst),
    .in_valid  (push), // RULE5 RULE9
    .in_ready  (fifo_in_ready),
    .in_data   (tx_bit),
    .out_valid (fifo_out_valid),
    .out_ready (load_out),
    .out_data  (fifo_out_data)
  );

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      txv_reg <= 1'b0;
      txd_reg <= 1'b0;
    end else if (load_out) begin
      txv_reg <= fifo_out_valid;
      txd_reg <= fifo_out_data;
    end
  end

  assign sdi_o           = sdi_o_reg;
  assign sdi_oe_n        = sdi_oe_n_reg;
  assign sdo_o           = sdo_reg;
  assign sdo_oe_n        = sdo_oe_n_reg;
  assign interrupt_out_n = irq_reg;
  assign gpio_clk_o      = gpio_clk_reg;
  assign sync_det_en     = sync_en_reg;
  assign tx_valid        = txv_reg;
  assign tx_data         = txd_reg;
endmodule
`default_nettype wire

//--- dps_defs.svh
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH
`define DPS_ROUTE_NONE  2'h0
`define DPS_ROUTE_GPIO  2'h1
`define DPS_ROUTE_SDO   2'h2
`define DPS_ROUTE_IRQ   2'h3
`define DPS_SRC_SDI     2'h1
`define DPS_DIV_W       16
`define DPS_DIV_ONE     16'h0001
`define DPS_DIV_ZERO    16'h0000
`define DPS_PN9_SEED    9'h1ff
`define DPS_PN9_MSB     8
`define DPS_PN9_TAP     4
`define DPS_FIFO_WIDTH  1
`define DPS_FIFO_DEPTH  32
`define DPS_FIFO_AW     5
`define DPS_INT_EN_W    8
`endif

//--- dps_pkg.sv
package dps_pkg;
  typedef enum logic [2:0] {
    DPS_CK_IDLE = 3'h1,
    DPS_CK_LOW  = 3'h2,
    DPS_CK_HIGH = 3'h4
  } dps_clk_st_t;
endpackage

//--- dps_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "dps_defs.svh"
module dps_fifo #(
  parameter int WIDTH = `DPS_FIFO_WIDTH,
  parameter int DEPTH = `DPS_FIFO_DEPTH,
  parameter int AW    = `DPS_FIFO_AW
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                            (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire              empty = (wr_ptr_reg == rd_ptr_reg);
  wire              push  = in_valid && !full;
  wire              pop   = out_ready && !empty;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

//--- dps_pin_mux_assertions.sv
`timescale 1ns/100ps
`default_nettype none
`include "dps_defs.svh"
module dps_pin_mux_assertions (
  input wire logic                  mclk,
  input wire logic                  nrst,
  input wire logic                  serial_select_n,
  input wire logic                  sdo_o,
  input wire logic                  interrupt_out_n,
  input wire logic                  gpio_clk_o,
  input wire logic                  spi_sdo,
  input wire logic                  irq_int_n,
  input wire logic                  irq_on_sdo,
  input wire logic [1:0]            clk_route,
  input wire logic                  tx_mode,
  input wire logic                  rx_mode,
  input wire logic [`DPS_DIV_W-1:0] half_period,
  input wire logic                  preamble_det,
  input wire logic                  sync_det_en,
  input wire logic                  tx_valid,
  input wire logic                  tx_ready,
  input wire logic                  tx_data
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);
  logic                  gpio_prev_reg;
  logic [`DPS_DIV_W-1:0] run_reg;
  // The run counter holds how many cycles the data clock pin has kept its level.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gpio_prev_reg <= 1'b0;
      run_reg       <= 16'h0;
    end else begin
      gpio_prev_reg <= gpio_clk_o;
      run_reg       <= (gpio_clk_o != gpio_prev_reg) ? 16'h1 : run_reg + 16'h1;
    end
  end
  property p_sdo_spi;
    (!serial_select_n) [*4] |-> sdo_o == $past(spi_sdo);
  endproperty
  a_sdo_spi: assert property (p_sdo_spi) else $error("sdo spi");
  property p_sdo_irq;
    (serial_select_n && clk_route != 2'h2 && irq_on_sdo) [*4] |-> sdo_o == $past(irq_int_n);
  endproperty
  a_sdo_irq: assert property (p_sdo_irq) else $error("sdo irq");
  property p_irq_pass;
    (clk_route != 2'h3) [*2] |-> interrupt_out_n == $past(irq_int_n);
  endproperty
  a_irq_pass: assert property (p_irq_pass) else $error("irq pin");
  property p_sync_on;
    preamble_det && rx_mode |=> sync_det_en;
  endproperty
  a_sync_on: assert property (p_sync_on) else $error("sync on");
  property p_sync_off;
    !rx_mode || (!preamble_det && !sync_det_en) |=> !sync_det_en;
  endproperty
  a_sync_off: assert property (p_sync_off) else $error("sync off");
  property p_clk_hi;
    disable iff (!nrst || (!tx_mode && !rx_mode))
    $fell(gpio_clk_o) && half_period != 16'h0 |-> run_reg == half_period;
  endproperty
  a_clk_hi: assert property (p_clk_hi) else $error("clock high");
  property p_clk_lo;
    disable iff (!nrst || (!tx_mode && !rx_mode))
    $rose(gpio_clk_o) && half_period != 16'h0 |-> run_reg >= half_period;
  endproperty
  a_clk_lo: assert property (p_clk_lo) else $error("clock low");
  property p_gpio_quiet;
    (clk_route != 2'h1) [*2] |-> !gpio_clk_o;
  endproperty
  a_gpio_quiet: assert property (p_gpio_quiet) else $error("gpio clock");
  property p_tx_hold;
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx hold");
endmodule
bind dps_pin_mux dps_pin_mux_assertions u_dps_pin_mux_assertions (
  .mclk, .nrst, .serial_select_n, .sdo_o, .interrupt_out_n, .gpio_clk_o, .spi_sdo,
  .irq_int_n, .irq_on_sdo, .clk_route, .tx_mode, .rx_mode, .half_period, .preamble_det,
  .sync_det_en, .tx_valid, .tx_ready, .tx_data
);
`default_nettype wire

//--- dps_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dps_host_model (
  input wire logic        dclk,
  input wire logic        en,
  input wire logic [63:0] pattern,
  output logic            drv
);
  logic [5:0] idx = 6'h0;
  logic       seen;
  logic       rel = 1'b0;
  // Bits advance on falling clock edges once a rising edge was seen.
  always @(posedge dclk or negedge en) seen <= en;
  always @(negedge dclk or negedge en) begin
    if (!en) idx <= 6'h0;
    else if (seen) idx <= idx + 6'h1;
  end
  always @(negedge en) rel <= ~pattern[idx];
  assign drv = en ? pattern[idx] : rel;
endmodule
`default_nettype wire

//--- dps_pin_mux_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "dps_defs.svh"
module dps_pin_mux_tb_top;
  logic        mclk, nrst, serial_select_n, sdi_i, sdi_o, sdi_oe_n, sdo_o, sdo_oe_n;
  logic        interrupt_out_n, gpio_data_i, gpio_clk_o, spi_sdo, spi_sdo_oe_n, irq_int_n;
  logic        irq_on_sdo, pn9_mode, tx_mode, rx_mode, rx_bit, preamble_det, sync_det_en;
  logic        tx_valid, tx_ready, tx_data, host_en, host_drv, dclk;
  logic [7:0]  int_en1, int_en2, rises_base;
  logic [7:0]  rises = 8'h0;
  logic [1:0]  clk_route, src_sel;
  logic [15:0] half_period;
  logic [63:0] pat;
  logic [8:0]  lfsr;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          n;
  dps_pin_mux u_dps_pin_mux (
    .mclk, .nrst, .serial_select_n, .sdi_i, .sdi_o, .sdi_oe_n, .sdo_o, .sdo_oe_n,
    .interrupt_out_n, .gpio_data_i, .gpio_clk_o, .spi_sdo, .spi_sdo_oe_n, .irq_int_n,
    .int_en1, .int_en2, .irq_on_sdo, .clk_route, .src_sel, .pn9_mode, .tx_mode, .rx_mode,
    .half_period, .rx_bit, .preamble_det, .sync_det_en, .tx_valid, .tx_ready, .tx_data
  );
  dps_host_model u_dps_host_model (.dclk(dclk), .en(host_en), .pattern(pat), .drv(host_drv));
  assign sdi_i       = !sdi_oe_n ? sdi_o : host_drv;
  assign gpio_data_i = host_drv;
  assign dclk = clk_route == 2'h2 ? sdo_o : clk_route == 2'h3 ? interrupt_out_n : gpio_clk_o;
  always @(posedge dclk) rises <= rises + 8'h1;
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  function automatic logic [2:0] mux_exp();
    logic zero_en;
    zero_en = int_en1 == 8'h0 && int_en2 == 8'h0;
    return {serial_select_n ? irq_int_n : spi_sdo, serial_select_n ? !irq_on_sdo : spi_sdo_oe_n,
            clk_route == 2'h3 && zero_en ? 1'b1 : irq_int_n};
  endfunction
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  initial begin
    void'($urandom(32'hcd806c33));
    {nrst, tx_mode, rx_mode, pn9_mode, preamble_det, rx_bit, spi_sdo, irq_on_sdo} = 8'h0;
    {serial_select_n, spi_sdo_oe_n, irq_int_n, tx_ready, host_en} = 5'h1e;
    {int_en1, int_en2, clk_route, src_sel} = 20'h00005;
    half_period = 16'ha;
    pat = 64'h0;
    repeat (10) @(negedge mclk);
    nrst = 1'b1;
    repeat (40) begin
      {serial_select_n, spi_sdo, spi_sdo_oe_n, irq_int_n, irq_on_sdo, clk_route} = 7'($urandom);
      int_en1 = $urandom_range(1) ? 8'h0 : 8'($urandom);
      int_en2 = $urandom_range(1) ? 8'h0 : 8'($urandom);
      repeat (5) @(negedge mclk);
      chk({5'h0, sdo_o, sdo_oe_n, interrupt_out_n}, {5'h0, mux_exp()});
    end
    for (int k = 0; k < 4; k++) begin
      {serial_select_n, irq_int_n, irq_on_sdo, int_en1, int_en2} = 19'h60000;
      clk_route = (k == 0) ? 2'h1 : 2'(k);
      pn9_mode = (k == 0);
      src_sel = 2'(k % 2);
      pat = {$urandom, $urandom};
      tx_ready = 1'b0;
      repeat (4) @(negedge mclk);
      rises_base = rises;
      host_en = 1'b1;
      tx_mode = 1'b1;
      repeat (800) @(negedge mclk);
      chk(rises - rises_base, 8'(`DPS_FIFO_DEPTH + 1));
      tx_ready = 1'b1;
      lfsr = 9'h1ff;
      for (int i = 0; i < 40; i++) begin
        for (n = 0; tx_valid !== 1'b1 && n < 200; n++) @(negedge mclk);
        chk({7'h0, tx_valid}, 8'h01);
        chk(tx_data, pn9_mode ? lfsr[8] : pat[i]);
        lfsr = {lfsr[7:0], lfsr[8] ^ lfsr[4]};
        @(negedge mclk);
      end
      {tx_mode, host_en} = 2'h0;
      repeat (200) @(negedge mclk);
    end
    {clk_route, src_sel, rx_mode} = 5'h0b;
    repeat (6) begin
      rx_bit = 1'($urandom);
      repeat (48) @(negedge mclk);
      chk({sdi_oe_n, sdi_o, sync_det_en}, {1'b0, rx_bit, 1'b0});
    end
    preamble_det = 1'b1;
    @(negedge mclk);
    preamble_det = 1'b0;
    @(negedge mclk);
    chk(sync_det_en, 1'b1);
    rx_mode = 1'b0;
    repeat (3) @(negedge mclk);
    chk({sync_det_en, sdi_oe_n}, 2'h1);
    conclude();
  end
endmodule
`default_nettype wire
